// File: common/strap_pkg.sv
// Behaviour
// - pin-selected equalization applies only while management select is in pin mode.
// - in management mode each channel takes eq and de-emphasis from its registers.
// - in management mode bank B eq pins become target address bits 2 and 3.
// - pin-selected de-emphasis applies only in pin mode, per bank from its own pins.
// - management mode reuses bank A de-emph pins as bus clock/data, bank B as address.
// - rate strap: low=gen1/2, float=auto with de-emph, 20k down=gen3 plain, high=reserved.
// - loop strap: low routes A in to B out, float normal, high routes B in to A out.
// - receiver-detect strap selects low-value or high-impedance input termination.
// - cable-absent high puts device in low power, low enables normal operation.
// - load request driven low starts an attempt to read settings from the eeprom.
// - failed eeprom load stalls forever and refuses all management access.
// - while stalled on failure the load-status output stays high.
// - management select: high gives target register access, float eeprom load, low pins.
// - load-status low when load passed, high when failed or incomplete.
package strap_pkg;
  // four-level strap codes
  localparam logic [1:0] LVL_LOW = 2'h0; // strong to ground
  localparam logic [1:0] LVL_WEAK_LOW = 2'h1; // weak pull-down
  localparam logic [1:0] LVL_FLOAT = 2'h2; // floating
  localparam logic [1:0] LVL_HIGH = 2'h3; // strong to supply
  // rate modes
  localparam logic [1:0] RATE_GEN12 = 2'h0;
  localparam logic [1:0] RATE_AUTO = 2'h1;
  localparam logic [1:0] RATE_GEN3 = 2'h2;
  localparam logic [1:0] RATE_RSVD = 2'h3;
  // loop routes
  localparam logic [1:0] LOOP_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_A_TO_B = 2'h1;
  localparam logic [1:0] LOOP_B_TO_A = 2'h2;
  // management modes
  localparam logic [1:0] MGMT_PIN = 2'h0;
  localparam logic [1:0] MGMT_EEPROM = 2'h1;
  localparam logic [1:0] MGMT_TARGET = 2'h2;
  localparam int NUM_CH = 8;
  localparam int BANK_CH = 4;
  localparam int SETTLE_CYCLES = 4; // strap stability filter length
  localparam logic [2:0] SETTLE_MAX = 3'h3;
  localparam logic [2:0] SETTLE_ZERO = 3'h0;
endpackage : strap_pkg

// File: rtl/strap_filter.sv
`timescale 1ns/10ps
// holds a two-bit strap code until the raw level stays steady
module strap_filter (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_n, // sync reset, active low
  input wire logic [1:0] i_level, // raw resolved level
  input wire logic [1:0] i_rst_val, // code after reset
  output logic [1:0] o_code // filtered code
);
  import strap_pkg::*;
  logic [1:0] last_reg;
  logic [2:0] cnt_reg;
  logic [1:0] code_reg;
  // track last level and its age
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      last_reg <= LVL_FLOAT;
      cnt_reg <= SETTLE_ZERO;
    end else if (i_level != last_reg) begin
      last_reg <= i_level;
      cnt_reg <= SETTLE_ZERO;
    end else if (cnt_reg != SETTLE_MAX) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
  // adopt level once steady
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      code_reg <= i_rst_val;
    end else if (cnt_reg == SETTLE_MAX && i_level == last_reg) begin
      code_reg <= last_reg;
    end
  end
  assign o_code = code_reg;
endmodule : strap_filter

// File: rtl/strap_mode_ctrl.sv
`timescale 1ns/10ps
module strap_mode_ctrl (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_n, // sync reset, active low
  input wire logic [1:0] i_mgmt_mode_select, // four-level code
  input wire logic [1:0] i_bank_a_eq_level, // four-level code
  input wire logic [1:0] i_bank_b_eq_level, // four-level code
  input wire logic [1:0] i_bank_a_deemph_level, // four-level code
  input wire logic [1:0] i_bank_b_deemph_level, // four-level code
  input wire logic [1:0] i_rate_select, // four-level code
  input wire logic [1:0] i_loop_route_select, // four-level code
  input wire logic [1:0] i_rx_termination_select, // four-level code
  input wire logic i_cable_absent, // high = no cable
  input wire logic i_load_req_n, // eeprom load request, active low
  input wire logic i_load_done, // eeprom engine finished
  input wire logic i_load_ok, // image valid with done
  input wire logic [2*strap_pkg::NUM_CH-1:0] i_reg_eq, // per-channel eq registers
  input wire logic [2*strap_pkg::NUM_CH-1:0] i_reg_deemph, // per-channel de-emph registers
  output logic [2*strap_pkg::NUM_CH-1:0] o_ch_eq, // applied eq per channel
  output logic [2*strap_pkg::NUM_CH-1:0] o_ch_deemph, // applied de-emph per channel
  output logic [1:0] o_mgmt_mode, // decoded management mode
  output logic [3:0] o_target_addr_straps, // target address bits
  output logic [1:0] o_bus_clk_data_level, // bus clk/data pin levels
  output logic o_bus_pins_active, // de-emph pins act as bus
  output logic [1:0] o_rate_mode, // decoded rate mode
  output logic [1:0] o_loop_route, // decoded loop route
  output logic o_rx_term_low, // 1 = low-value termination
  output logic o_low_power, // low power mode
  output logic o_load_start, // one-cycle load start pulse
  output logic o_mgmt_access_en, // management access allowed
  output logic o_load_status // high = failed or incomplete
);
  import strap_pkg::*;
  typedef enum {LD_IDLE, LD_BUSY, LD_PASS, LD_STALL} load_e;
  logic [1:0] f_mgmt, f_eqa, f_eqb, f_dema, f_demb, f_rate, f_loop, f_rx;
  load_e ld_reg;
  load_e ld_next;
  logic req_n_reg;
  logic [2*NUM_CH-1:0] eq_reg, dem_reg;
  logic [1:0] mode_reg, rate_reg, loop_reg;
  logic [3:0] addr_reg;
  logic [1:0] bus_reg;
  logic term_reg, lp_reg;
  // filter every four-level strap into a stable code
  strap_filter u_f_mgmt (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_level(i_mgmt_mode_select), .i_rst_val(LVL_LOW), .o_code(f_mgmt));
  strap_filter u_f_eqa (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_level(i_bank_a_eq_level), .i_rst_val(LVL_LOW), .o_code(f_eqa));
  strap_filter u_f_eqb (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_level(i_bank_b_eq_level), .i_rst_val(LVL_LOW), .o_code(f_eqb));
  strap_filter u_f_dema (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_level(i_bank_a_deemph_level), .i_rst_val(LVL_LOW), .o_code(f_dema));
  strap_filter u_f_demb (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_level(i_bank_b_deemph_level), .i_rst_val(LVL_LOW), .o_code(f_demb));
  strap_filter u_f_rate (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_level(i_rate_select), .i_rst_val(LVL_FLOAT), .o_code(f_rate));
  strap_filter u_f_loop (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_level(i_loop_route_select), .i_rst_val(LVL_FLOAT), .o_code(f_loop));
  strap_filter u_f_rx (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_level(i_rx_termination_select), .i_rst_val(LVL_HIGH), .o_code(f_rx));

  // management mode decode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mode_reg <= MGMT_PIN;
    end else begin
      case (f_mgmt)
        LVL_HIGH: mode_reg <= MGMT_TARGET;
        LVL_FLOAT: mode_reg <= MGMT_EEPROM;
        default: mode_reg <= MGMT_PIN;
      endcase
    end
  end

  // per-channel eq and de-emph: banks in pin mode, registers otherwise
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          eq_reg[2*ch +: 2] <= LVL_LOW;
          dem_reg[2*ch +: 2] <= LVL_LOW;
        end else if (mode_reg == MGMT_PIN) begin
          eq_reg[2*ch +: 2] <= (ch < BANK_CH) ? f_eqa : f_eqb;
          dem_reg[2*ch +: 2] <= (ch < BANK_CH) ? f_dema : f_demb;
        end else begin
          eq_reg[2*ch +: 2] <= i_reg_eq[2*ch +: 2];
          dem_reg[2*ch +: 2] <= i_reg_deemph[2*ch +: 2];
        end
      end
    end
  endgenerate

  // pin reuse as address and bus lines outside pin mode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      addr_reg <= 4'h0;
      bus_reg <= 2'h0;
    end else if (f_mgmt == LVL_HIGH || f_mgmt == LVL_FLOAT) begin
      // same decode as the mode register, so address and mode switch on one edge
      addr_reg <= {f_eqb, f_demb};
      bus_reg <= {i_bank_a_deemph_level[1], i_bank_a_deemph_level[0]};
    end else begin
      addr_reg <= 4'h0;
      bus_reg <= 2'h0;
    end
  end

  // rate, loop, termination and power decode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rate_reg <= RATE_AUTO;
      loop_reg <= LOOP_NORMAL;
      term_reg <= 1'h0;
      lp_reg <= 1'h0;
    end else begin
      case (f_rate)
        LVL_LOW: rate_reg <= RATE_GEN12;
        LVL_FLOAT: rate_reg <= RATE_AUTO;
        LVL_WEAK_LOW: rate_reg <= RATE_GEN3;
        default: rate_reg <= RATE_RSVD;
      endcase
      case (f_loop)
        LVL_LOW, LVL_WEAK_LOW: loop_reg <= LOOP_A_TO_B;
        LVL_HIGH: loop_reg <= LOOP_B_TO_A;
        default: loop_reg <= LOOP_NORMAL;
      endcase
      term_reg <= (f_rx == LVL_HIGH) || (f_rx == LVL_FLOAT);
      lp_reg <= i_cable_absent;
    end
  end

  // eeprom load sequencer
  always_comb begin
    ld_next = ld_reg;
    case (ld_reg)
      LD_IDLE: begin
        if (req_n_reg && !i_load_req_n) begin
          ld_next = LD_BUSY;
        end
      end
      LD_BUSY: begin
        if (i_load_done) begin
          ld_next = i_load_ok ? LD_PASS : LD_STALL;
        end
      end
      LD_PASS: begin
        if (req_n_reg && !i_load_req_n) begin
          ld_next = LD_BUSY;
        end
      end
      LD_STALL: ld_next = LD_STALL;
      default: ld_next = LD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ld_reg <= LD_IDLE;
      req_n_reg <= 1'h1;
    end else begin
      ld_reg <= ld_next;
      req_n_reg <= i_load_req_n;
    end
  end

  assign o_ch_eq = eq_reg;
  assign o_ch_deemph = dem_reg;
  assign o_mgmt_mode = mode_reg;
  assign o_target_addr_straps = addr_reg;
  assign o_bus_clk_data_level = bus_reg;
  assign o_bus_pins_active = (mode_reg != MGMT_PIN);
  assign o_rate_mode = rate_reg;
  assign o_loop_route = loop_reg;
  assign o_rx_term_low = term_reg;
  assign o_low_power = lp_reg;
  assign o_load_start = (ld_reg == LD_BUSY) && (ld_next == LD_BUSY) ? 1'h0 :
                        (ld_next == LD_BUSY);
  // access refused while stalled or while loading
  assign o_mgmt_access_en = (mode_reg != MGMT_PIN) && (ld_reg != LD_STALL)
                            && (ld_reg != LD_BUSY);
  assign o_load_status = (ld_reg != LD_PASS);
endmodule : strap_mode_ctrl

// File: dv/strap_mode_ctrl_sva.sv
`timescale 1ns/10ps
module strap_mode_ctrl_sva import strap_pkg::*; (
  input wire logic i_clk_sys, // clock
  input wire logic i_rst_n, // reset
  input wire logic i_cable_absent, // no cable
  input wire logic i_load_req_n, // load request
  input wire logic i_load_done, // engine done
  input wire logic i_load_ok, // image valid
  input wire logic [2*strap_pkg::NUM_CH-1:0] i_reg_eq, // eq regs
  input wire logic [2*strap_pkg::NUM_CH-1:0] o_ch_eq, // applied eq
  input wire logic [1:0] o_mgmt_mode, // mode
  input wire logic [3:0] o_target_addr_straps, // address
  input wire logic [1:0] o_bus_clk_data_level, // bus pins
  input wire logic o_bus_pins_active, // bus active
  input wire logic o_low_power, // low power
  input wire logic o_load_start, // start pulse
  input wire logic o_mgmt_access_en, // access
  input wire logic o_load_status // load status
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // low power tracks the cable input one cycle late
  a_low_power_follow: assert property (
    $past(i_rst_n) |-> o_low_power == $past(i_cable_absent)) else $error("low power lag");
  // pin mode gives every channel of a bank the same eq
  a_bank_eq_alike: assert property (
    o_mgmt_mode == MGMT_PIN && $past(o_mgmt_mode) == MGMT_PIN
    |-> o_ch_eq[15:8] == {4{o_ch_eq[9:8]}} && o_ch_eq[7:0] == {4{o_ch_eq[1:0]}})
    else $error("bank eq differs");
  // management mode takes eq from the registers
  a_mgmt_reg_eq: assert property (
    o_mgmt_mode != MGMT_PIN && $past(o_mgmt_mode) != MGMT_PIN |-> o_ch_eq == $past(i_reg_eq))
    else $error("eq not from registers");
  // pin mode keeps address and bus pins quiet
  a_pin_addr_zero: assert property (
    o_mgmt_mode == MGMT_PIN |-> o_target_addr_straps == 4'h0
    && o_bus_clk_data_level == 2'h0 && !o_bus_pins_active) else $error("pin mode reuse");
  a_pin_no_access: assert property (
    o_mgmt_mode == MGMT_PIN |-> !o_mgmt_access_en) else $error("access in pin mode");
  // start only on a falling request, then status high and access shut on the next cycle
  a_start_on_fall: assert property (
    o_load_start |-> (!i_load_req_n && $past(i_load_req_n))
    ##1 (o_load_status && !o_mgmt_access_en))
    else $error("bad load start");
  a_pass_clears: assert property (
    o_load_status && i_load_done && i_load_ok |=> !o_load_status) else $error("pass not shown");
  // a failed image stalls with status high and no access
  a_fail_stalls: assert property (
    o_load_status && i_load_done && !i_load_ok |=> (o_load_status && !o_mgmt_access_en) [*8])
    else $error("failed load not stalled");
endmodule : strap_mode_ctrl_sva
bind strap_mode_ctrl strap_mode_ctrl_sva strap_mode_ctrl_sva_inst (.i_clk_sys, .i_rst_n,
  .i_cable_absent, .i_load_req_n, .i_load_done, .i_load_ok, .i_reg_eq, .o_ch_eq, .o_mgmt_mode,
  .o_target_addr_straps, .o_bus_clk_data_level, .o_bus_pins_active, .o_low_power,
  .o_load_start, .o_mgmt_access_en, .o_load_status);

// File: dv/eeprom_model.sv
`timescale 1ns/10ps
// eeprom engine stand-in: answers a load start after DELAY cycles
module eeprom_model #(parameter int DELAY = 6) (
  input wire logic i_clk_sys, // clock
  input wire logic i_start, // load start
  input wire logic i_good, // image valid
  output logic o_done, // finished
  output logic o_ok // valid with done
);
  int cnt = 0;
  initial o_done = 1'h0;
  initial o_ok = 1'h0;
  // ok toggles outside done so nothing stale looks valid
  always @(posedge i_clk_sys) begin
    o_done <= (cnt == 1);
    o_ok <= (cnt == 1) ? i_good : ~o_ok;
    if (i_start) cnt <= DELAY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : eeprom_model

// File: dv/strap_mode_ctrl_tb_top.sv
`timescale 1ns/10ps
module strap_mode_ctrl_tb_top;
  import strap_pkg::*;
  logic i_clk_sys = 0, i_rst_n = 0, i_cable_absent = 0, i_load_req_n = 1, good = 1;
  logic [1:0] mm = 0, ea = 0, eb = 0, da = 0, db = 0, rt = 2, lp = 2, rx = 2;
  logic [15:0] reg_eq = 16'hE41B, reg_de = 16'h1BE4;
  logic [1:0] rate_tab [4] = '{RATE_GEN12, RATE_GEN3, RATE_AUTO, RATE_RSVD};
  logic [1:0] loop_tab [4] = '{LOOP_A_TO_B, LOOP_A_TO_B, LOOP_NORMAL, LOOP_B_TO_A};
  wire [15:0] o_ch_eq, o_ch_deemph;
  wire [1:0] o_mgmt_mode, o_bus_clk_data_level, o_rate_mode, o_loop_route;
  wire [3:0] o_target_addr_straps;
  wire o_bus_pins_active, o_rx_term_low, o_low_power, o_load_start, o_mgmt_access_en;
  wire o_load_status, i_load_done, i_load_ok;
  int fail_count = 0, checks_done = 0;
  strap_mode_ctrl strap_mode_ctrl_inst (.i_clk_sys, .i_rst_n, .i_mgmt_mode_select(mm),
    .i_bank_a_eq_level(ea), .i_bank_b_eq_level(eb), .i_bank_a_deemph_level(da),
    .i_bank_b_deemph_level(db), .i_rate_select(rt), .i_loop_route_select(lp),
    .i_rx_termination_select(rx), .i_cable_absent, .i_load_req_n, .i_load_done, .i_load_ok,
    .i_reg_eq(reg_eq), .i_reg_deemph(reg_de), .o_ch_eq, .o_ch_deemph, .o_mgmt_mode,
    .o_target_addr_straps, .o_bus_clk_data_level, .o_bus_pins_active, .o_rate_mode,
    .o_loop_route, .o_rx_term_low, .o_low_power, .o_load_start, .o_mgmt_access_en,
    .o_load_status);
  eeprom_model eeprom_model_inst (.i_clk_sys, .i_start(o_load_start), .i_good(good),
    .o_done(i_load_done), .o_ok(i_load_ok));
  // clock
  always #25 i_clk_sys = ~i_clk_sys;
  task step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #5;
  endtask : step
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  // set all straps and let filter plus decode settle
  task straps(input logic [15:0] v);
    {mm, ea, eb, da, db, rt, lp, rx} = v;
    step(12);
  endtask : straps
  // falling request, then let the model answer
  task load(input logic g);
    good = g;
    i_load_req_n = 0;
    #1 chk(o_load_start, 1, "load start");
    step(1);
    i_load_req_n = 1;
    step(20);
  endtask : load
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    step(2);
    chk(o_load_status, 1, "status in reset");
    i_rst_n = 1;
    for (int c = 0; c < 4; c++) begin
      straps({2'h0, c[1:0], ~c[1:0], c[1:0], ~c[1:0], c[1:0], c[1:0], c[1:0]});
      chk(o_ch_eq, {{4{~c[1:0]}}, {4{c[1:0]}}}, "bank eq");
      chk(o_ch_deemph, {{4{~c[1:0]}}, {4{c[1:0]}}}, "bank de-emph");
      chk(o_rate_mode, rate_tab[c], "rate");
      chk(o_loop_route, loop_tab[c], "loop");
      chk(o_rx_term_low, c >= 2, "termination");
    end
    rt = 2'h0;
    step(3);
    chk(o_rate_mode, RATE_RSVD, "glitch seen");
    rt = 2'h3;
    step(8);
    chk(o_rate_mode, RATE_RSVD, "glitch passed");
    $display("test pin mode done");
    straps({2'h3, 2'h0, 2'h2, 2'h3, 2'h1, 2'h2, 2'h2, 2'h2});
    chk(o_mgmt_mode, MGMT_TARGET, "target mode");
    chk(o_ch_eq, reg_eq, "reg eq");
    chk(o_ch_deemph, reg_de, "reg de-emph");
    chk(o_target_addr_straps, 4'h9, "address");
    chk({o_bus_pins_active, o_bus_clk_data_level}, 3'h7, "bus pins");
    chk(o_low_power, 0, "full power");
    i_cable_absent = 1;
    step(1);
    chk(o_low_power, 1, "low power");
    $display("test target mode done");
    // back to pin mode: banks follow pins again, reused pins go quiet
    straps({2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h2, 2'h2});
    chk(o_mgmt_mode, MGMT_PIN, "pin mode again");
    chk(o_ch_eq, {{4{2'h2}}, {4{2'h1}}}, "eq back in pin mode");
    chk(o_ch_deemph, {{4{2'h1}}, {4{2'h3}}}, "de-emph back in pin mode");
    chk({o_bus_pins_active, o_bus_clk_data_level, o_target_addr_straps}, 7'h0, "pins freed");
    $display("test pin mode return done");
    straps({2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h2, 2'h2, 2'h2});
    chk(o_mgmt_mode, MGMT_EEPROM, "eeprom mode");
    load(1);
    chk(o_load_status, 0, "load pass");
    load(0);
    chk({o_load_status, o_mgmt_access_en}, 2'h2, "load stall");
    $display("test eeprom load done");
    // only a reset leaves the stall; a fresh load then passes
    i_rst_n = 0;
    step(2);
    chk({o_load_status, o_mgmt_access_en, o_mgmt_mode}, {1'h1, 1'h0, MGMT_PIN}, "reset state");
    i_rst_n = 1;
    step(12);
    load(1);
    chk({o_load_status, o_mgmt_access_en}, 2'h1, "pass after reset");
    $display("test reset recovery done");
    test_done();
  end
  // watchdog
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule : strap_mode_ctrl_tb_top
